/* hdl/padc_map.svh */
`ifndef PADC_MAP_SVH
`define PADC_MAP_SVH
`define PADC_STAGES       10
`define PADC_CODE_W       10
`define PADC_DEC_W        2
`define PADC_LAT_HALF     11
`define PADC_FIFO_DEPTH   8
`define PADC_CODE_MID     10'h200
`define PADC_CODE_RESET   10'h000
`define PADC_DEC_LOW      2'h0
`define PADC_DEC_MID      2'h1
`define PADC_DEC_HIGH     2'h2
`endif

/* hdl/padc_pkg.sv */
`include "padc_map.svh"
package padc_pkg;
    typedef logic [`PADC_DEC_W-1:0]  padc_dec_type;
    typedef logic [`PADC_CODE_W-1:0] padc_code_type;
    typedef struct packed {
        logic          valid;
        padc_code_type code;
    } padc_word_type;
    typedef enum logic [1:0] {PADC_RUN, PADC_SLEEP} padc_mode_type;
endpackage

/* hdl/padc_fifo.sv */
`timescale 1ns/1ps
`include "padc_map.svh"
module padc_fifo
    import padc_pkg::*;
#(
    parameter int WIDTH = `PADC_CODE_W,
    parameter int DEPTH = `PADC_FIFO_DEPTH
)(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             enable,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   count;
        logic [WIDTH-1:0] dout;
        logic          dvalid;
    } padc_fifo_state_type;

    padc_fifo_state_type   st_r;
    padc_fifo_state_type   st_nxt;
    logic [WIDTH-1:0]      mem_r [DEPTH];
    logic                  push;
    logic                  pop;

    // The read word lives in a register so the consumer sees a flop, at the cost of one cycle.
    assign in_ready  = (st_r.count != DEPTH[AW:0]);
    assign out_valid = st_r.dvalid;
    assign out_data  = st_r.dout;

    always_comb
    begin
        st_nxt = st_r;
        push   = in_valid && in_ready;
        pop    = (st_r.count != '0) && (!st_r.dvalid || out_ready);
        if (out_ready && st_r.dvalid)
        begin
            st_nxt.dvalid = 1'b0;
        end
        if (push)
        begin
            st_nxt.wr = st_r.wr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rd     = st_r.rd + 1'b1;
            st_nxt.dout   = mem_r[st_r.rd];
            st_nxt.dvalid = 1'b1;
        end
        st_nxt.count = st_r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else if (enable)
        begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (enable && push)
        begin
            mem_r[st_r.wr] <= in_data;
        end
    end
endmodule // padc_fifo

/* hdl/padc_core.sv */
`timescale 1ns/1ps
`include "padc_map.svh"
module padc_core
    import padc_pkg::*;
#(
    parameter int STAGES   = `PADC_STAGES,
    parameter int CODE_W   = `PADC_CODE_W,
    parameter int FIFO_DEP = `PADC_FIFO_DEPTH
)(
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                clock_enable,
    input  wire logic [2*STAGES-1:0] stage_decisions_in,
    input  wire logic                sleep_request_in,
    input  wire logic                output_disable_in,
    input  wire logic                reference_grounded_in,
    output logic      [CODE_W-1:0]   sample_code_out,
    output logic      [CODE_W-1:0]   sample_code_oe,
    output logic                     code_valid_out,
    output logic                     reference_buffers_on_out,
    output logic                     sleeping_out
);
    // Stage decisions arrive from the comparators, two bits per stage, stage 0 in the low bits.
    // Each decision is 0, 1 or 2 meaning -1/2, 0 or +1/2 of the stage range.
    localparam int HALVES = `PADC_LAT_HALF;
    // The FIFO costs two edges and the output latch one, so the tap sits that much earlier.
    localparam int OUT_TAP = (HALVES - 1) / 2 - 3;

    typedef struct packed {
        logic [2*STAGES-1:0]   fall_dec;
        logic                  fall_run;
        logic [HALVES-2:0]     run_pipe;
        logic [HALVES-2:0][CODE_W-1:0] pipe_code;
        logic [CODE_W-1:0]     last_code;
        padc_mode_type         mode;
        logic [CODE_W-1:0]     code_out;
        logic [CODE_W-1:0]     code_oe;
        logic                  valid;
        logic                  ref_on;
        logic                  asleep;
        logic                  fifo_pop;
    } padc_state_type;

    padc_state_type        st_r;
    padc_state_type        st_nxt;
    logic                  fall_run_r;
    logic [2*STAGES-1:0]   fall_dec_r;
    logic [CODE_W-1:0]     corrected;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic [CODE_W-1:0]     fifo_out_data;

    // Sampling happens on the falling edge; only the capture flops live on that edge.
    always_ff @(negedge clock or posedge reset)
    begin
        if (reset)
        begin
            fall_dec_r <= '0;
            fall_run_r <= 1'b0;
        end
        else if (clock_enable)
        begin
            fall_dec_r <= stage_decisions_in;
            fall_run_r <= !sleep_request_in;
        end
    end

    // Overlapping 1.5-bit stages add with one-bit overlap, so comparator offsets fold away.
    function automatic logic [CODE_W-1:0] padc_correct(input logic [2*STAGES-1:0] dec);
        int acc;
        acc = 1 << (CODE_W - 1);
        for (int i = 0; i < STAGES; i++)
        begin
            acc = acc + (int'(dec[2*i +: 2]) - 1) * (1 << (STAGES - 1 - i));
        end
        // All mid decisions leave the offset untouched, so bipolar zero gives 10 0000 0000.
        if (acc > (1 << CODE_W) - 1)
        begin
            return {CODE_W{1'b1}};
        end
        if (acc < 0)
        begin
            return '0;
        end
        return acc[CODE_W-1:0];
    endfunction

    assign corrected = padc_correct(fall_dec_r);

    always_comb
    begin
        st_nxt = st_r;
        // Half period into the rising edge, then ten more half periods: 5.5 cycles total.
        st_nxt.run_pipe     = {st_r.run_pipe[HALVES-3:0], fall_run_r};
        st_nxt.pipe_code[0] = corrected;
        for (int i = 1; i < HALVES - 1; i++)
        begin
            st_nxt.pipe_code[i] = st_r.pipe_code[i-1];
        end
        st_nxt.fifo_pop = 1'b1;
        unique case (st_r.mode)
            PADC_RUN:
            begin
                if (sleep_request_in)
                begin
                    st_nxt.mode = PADC_SLEEP;
                end
            end
            PADC_SLEEP:
            begin
                if (!sleep_request_in)
                begin
                    st_nxt.mode = PADC_RUN;
                end
            end
        endcase
        st_nxt.asleep = (st_nxt.mode == PADC_SLEEP);
        // In sleep the output latch is frozen on the last code.
        if (fifo_out_valid && st_r.mode == PADC_RUN)
        begin
            st_nxt.code_out  = fifo_out_data;
            st_nxt.last_code = fifo_out_data;
            st_nxt.valid     = 1'b1;
        end
        else
        begin
            st_nxt.code_out = st_r.last_code;
            st_nxt.valid    = 1'b0;
        end
        // Drive only while output disable is low; sleeping does not release them on its own.
        st_nxt.code_oe = output_disable_in ? '0 : '1;
        st_nxt.ref_on  = !reference_grounded_in && !sleep_request_in;
    end

    // Tap OUT_TAP of the latency line feeds the FIFO; it can only fill if output is blocked, and a word pushed while full is dropped, not stalled.
    padc_fifo #(
        .WIDTH (CODE_W),
        .DEPTH (FIFO_DEP)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .enable    (clock_enable),
        .in_valid  (st_r.run_pipe[OUT_TAP]),
        .in_ready  (fifo_in_ready),
        .in_data   (st_r.pipe_code[OUT_TAP]),
        .out_valid (fifo_out_valid),
        .out_ready (st_r.mode == PADC_RUN),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else if (clock_enable)
        begin
            st_r <= st_nxt;
        end
    end

    assign sample_code_out          = st_r.code_out;
    assign sample_code_oe           = st_r.code_oe;
    assign code_valid_out           = st_r.valid;
    assign reference_buffers_on_out = st_r.ref_on;
    assign sleeping_out             = st_r.asleep;

    a_oe_follows: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> (sample_code_oe == ($past(output_disable_in) ? '0 : '1)))
        else $error("output enable does not follow disable input");
    a_tristate_sleep: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && output_disable_in && sleep_request_in) |=> (sample_code_oe == '0))
        else $error("data lines not released in sleep");
    a_hold_sleep: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && st_r.mode == PADC_SLEEP && $past(st_r.mode == PADC_SLEEP)) |=> $stable(sample_code_out))
        else $error("code changed while sleeping");
    a_sleep_mode: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && sleep_request_in) |=> sleeping_out)
        else $error("sleep not entered");
    a_wake_mode: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && !sleep_request_in) |=> !sleeping_out)
        else $error("sleep not left");
    a_ref_off: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && reference_grounded_in) |=> !reference_buffers_on_out)
        else $error("reference buffers left on");
    a_valid_source: assert property (@(posedge clock) disable iff (reset)
        code_valid_out |-> !$past(st_r.mode == PADC_SLEEP))
        else $error("valid code during sleep");
    a_mid_code: assert property (@(posedge clock) disable iff (reset)
        (fall_dec_r == {STAGES{`PADC_DEC_MID}}) |-> (corrected == `PADC_CODE_MID))
        else $error("bipolar zero not offset binary");
endmodule // padc_core

/* verification/padc_capture.sv */
`timescale 1ns/1ps
module padc_capture
    import padc_pkg::*;
#(
    parameter int WAKE_HOLD = 12
)(
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire padc_code_type code_in,
    input  wire logic          valid_in,
    input  wire logic          sleeping_in,
    output padc_word_type      word_out
);
    logic [4:0] wake_r;
    // Codes made around sleep are stale, so they are dropped until the pipe refills.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wake_r   <= 5'h00;
            word_out <= '0;
        end
        else
        begin
            wake_r         <= sleeping_in ? 5'(WAKE_HOLD) : wake_r - 5'(wake_r != 5'h00);
            word_out.valid <= valid_in && !sleeping_in && wake_r == 5'h00;
            word_out.code  <= valid_in ? code_in : word_out.code;
        end
    end
endmodule // padc_capture

/* verification/tb_pipelined_adc_output_control.sv */
`timescale 1ns/1ps
module tb_pipelined_adc_output_control
    import padc_pkg::*;
;
    logic          clock;
    logic          reset;
    logic          clk_en;
    logic [19:0]   dec;
    logic          sleep;
    logic          dis;
    logic          gnd;
    padc_code_type code;
    padc_code_type oe;
    logic          valid;
    logic          ref_on;
    logic          sleeping;
    padc_word_type cap;
    padc_code_type exp_q[$];
    padc_code_type held;
    logic          drop;
    int            fail_count;
    int            num_checks;

    padc_core i_padc_core (.clock(clock), .reset(reset), .clock_enable(clk_en), .stage_decisions_in(dec),
        .sleep_request_in(sleep), .output_disable_in(dis), .reference_grounded_in(gnd), .sample_code_out(code),
        .sample_code_oe(oe), .code_valid_out(valid), .reference_buffers_on_out(ref_on), .sleeping_out(sleeping));
    padc_capture i_padc_capture (.clock(clock), .reset(reset), .code_in(code), .valid_in(valid),
        .sleeping_in(sleeping), .word_out(cap));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task print_verdict;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task compare_code(input padc_code_type got, input padc_code_type exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task compare_bit(input logic got, input logic exp);
        compare_code({9'h000, got}, {9'h000, exp});
    endtask

    // Our own reckoning: offset binary around mid scale, saturated at both ends.
    function padc_code_type correct(input logic [19:0] d);
        int s;
        s = int'(32'h200);
        for (int i = 0; i < 10; i++)
            s += (int'(d[2*i+:2]) - 1) * (1 << (9 - i));
        if (s > int'(32'h3FF))
            return 10'h3FF;
        if (s < 0)
            return 10'h000;
        return padc_code_type'(s);
    endfunction

    function logic [19:0] rnd();
        logic [19:0] r;
        for (int i = 0; i < 10; i++)
            r[2*i+:2] = 2'($urandom % 3);
        return r;
    endfunction

    // The value set here is sampled at the next falling edge, one sample per clock.
    task send(input logic [19:0] d);
        @(negedge clock);
        dec    <= d;
        clk_en <= 1'b1;
        if (!drop)
            exp_q.push_back(correct(d));
    endtask

    always @(negedge clock)
    begin
        if (cap.valid === 1'b1 && !drop)
        begin
            if (exp_q.size() == 0)
                compare_code(cap.code, 10'h000);
            else
                compare_code(cap.code, exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        fail_count++;
        print_verdict;
    end

    initial
    begin
        reset = 1'b1;
        clk_en = 1'b0;
        dec = 20'h00000;
        sleep = 1'b0;
        dis = 1'b0;
        gnd = 1'b0;
        drop = 1'b0;
        fail_count = 0;
        num_checks = 0;
        void'($urandom(61));
        repeat (3) @(posedge clock);
        @(negedge clock);
        reset <= 1'b0;
        send(20'h00000);
        send(20'h00001);
        send(20'hAAAAA);
        send(20'h55555);
        send(20'h80000);
        repeat (30) send(rnd());
        dis <= 1'b1;
        repeat (2) send(rnd());
        compare_code(oe, 10'h000);
        dis <= 1'b0;
        repeat (2) send(rnd());
        compare_code(oe, 10'h3FF);
        gnd <= 1'b1;
        repeat (2) send(rnd());
        compare_bit(ref_on, 1'b0);
        gnd <= 1'b0;
        repeat (2) send(rnd());
        compare_bit(ref_on, 1'b1);
        compare_bit(exp_q.size() inside {[5:10]}, 1'b1);
        drop = 1'b1;
        sleep <= 1'b1;
        repeat (2) send(rnd());
        compare_bit(sleeping, 1'b1);
        compare_bit(ref_on, 1'b0);
        held = code;
        repeat (8) send(rnd());
        compare_code(code, held);
        compare_code(oe, 10'h3FF);
        dis <= 1'b1;
        repeat (2) send(rnd());
        compare_code(oe, 10'h000);
        sleep <= 1'b0;
        dis <= 1'b0;
        repeat (20) send(rnd());
        compare_bit(sleeping, 1'b0);
        print_verdict;
    end
endmodule // tb_pipelined_adc_output_control
